// File: rtl/ecs_pkg.sv
package ecs_pkg;
	// Timing base
	localparam int CLK_KHZ = 25000;
	localparam int MF_PERIOD_US = 2000;
	localparam int MF_PERIOD_CYC = MF_PERIOD_US * CLK_KHZ / 1000;
	localparam int DEBOUNCE_MS = 14;
	localparam int DEBOUNCE_MF = DEBOUNCE_MS * 1000 / MF_PERIOD_US;
	localparam int FRAMES_PER_MF = 16;
	localparam logic [4:0] LOW_CHAN_OFS = 5'h0F;
	localparam logic [4:0] LAST_CHAN = 5'h1E;
	localparam logic [3:0] LAST_FRAME = 4'hF;
	localparam logic [3:0] ALIGN_NIBBLE = 4'h0;
	localparam logic [3:0] UNUSED_NIBBLE_FILL = 4'hF;
	// Interrupt period selection codes, and period lengths in multiframe ticks minus one
	localparam logic [1:0] PERIOD_2MS = 2'h0;
	localparam logic [1:0] PERIOD_8MS = 2'h1;
	localparam logic [2:0] TICKS_2MS_LAST = 3'h0;
	localparam logic [2:0] TICKS_8MS_LAST = 3'h3;
	localparam logic [2:0] TICKS_16MS_LAST = 3'h7;
	// Register byte addresses
	localparam logic [11:0] ADDR_GLOBAL_STREAM_CONFIG = 12'h900;
	localparam logic [11:0] ADDR_ALARM_FRAMING_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_INTERRUPT_IO_CONTROL = 12'h008;
	localparam logic [11:0] ADDR_DATALINK_SIGNALING_CONTROL = 12'h00C;
	localparam logic [11:0] ADDR_SIGNALING_INTERRUPT_PERIOD = 12'h010;
	localparam logic [11:0] ADDR_SIGNALING_CONTROL_DATA = 12'h014;
	localparam logic [11:0] ADDR_HDLC_COMMON_CHANNEL_CONTROL = 12'h018;
	localparam logic [11:0] ADDR_SYNC_REMOTE_STATUS = 12'h040;
	localparam logic [11:0] ADDR_SIGNALING_LATCH_STATUS = 12'h098;
	localparam logic [11:0] ADDR_SIGNALING_INTERRUPT_STATUS = 12'h0D8;
	localparam logic [11:0] ADDR_NATIONAL_INTERRUPT_MASK = 12'h118;
	// Per-channel pages: address = {page, 1'b0, channel[4:0], 2'b00}
	localparam logic [3:0] PAGE_TX_SIGNALING = 4'h4;
	localparam logic [3:0] PAGE_RX_SIGNALING = 4'h5;
	localparam logic [3:0] PAGE_TIMESLOT_CONTROL = 4'h6;
	// Field positions
	localparam int BIT_RATE_SEL = 0;
	localparam int BIT_FORMAT_SEL = 1;
	localparam int BIT_TS16_AIS = 0;
	localparam int BIT_IMA_MODE = 1;
	localparam int BIT_OUT_ENABLE = 0;
	localparam int BIT_RX_OUT_SEL = 1;
	localparam int BIT_COMMON_SIG_SEL = 0;
	localparam int BIT_RX_TRANSPARENT = 1;
	localparam int BIT_DEBOUNCE_EN = 0;
	localparam int BIT_FREEZE_FLAG = 1;
	localparam int BIT_CLEAR_CHANNEL = 0;
	localparam int BIT_TX_SOURCE_SEL = 1;
	localparam int BIT_SYNC_LOSS = 0;
	localparam int BIT_CHANGE = 0;
	// Reset values
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [3:0] RST_NIBBLE = 4'hF;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b01,
		ST_SYNC = 2'b10
	} ecs_align_state_type;

	// One timeslot-16 byte from the receive framer, line bit 1 in bit 7
	typedef struct packed {
		logic valid;
		logic basic_sync;
		logic [7:0] data;
	} ecs_ts16_in_type;

	// One backplane timeslot from the input control stream
	typedef struct packed {
		logic valid;
		logic [4:0] slot;
		logic [7:0] data;
	} ecs_stream_in_type;
endpackage

// File: rtl/ecs_cas_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Stream nibbles carry A,B,C,D in bits 3,2,1,0 both ways.
// - Signaling multiframe is 16 frames, 0 to 15, every 2 msec.
// - Multiframe counter is independent of the CRC-4 multiframe.
// - Frame 0 sends 0000 in upper nibble; receiver aligns on it.
// - Spare bits 5, 7, 8 of frame 0 are sent as one.
// - Bit 6 of frame 0 is zero when aligned, one otherwise.
// - Frame k carries channel k upper, channel k+15 lower.
// - Global bits pick stream rate and backplane format.
// - Timeslot-16 alarm transmit stops signaling insertion.
// - Signaling is off in inverse multiplexing mode.
// - Output stream driven only with enable and receive select both set.
// - Period bits pick 2, 8 or 16 msec; one interrupt per period.
// - Sync loss freezes receive signaling and sets freeze flag.
// - With debounce on, value must hold 14 msec before use.
// - Receive signaling is valid only while sync loss is low.
// - A change on any channel without its clear-channel bit sets a latched status bit.
// - Change interrupt status set per period; mask bit suppresses it.
// - Clear-channel bit blocks transmit insertion for that channel.
// - Source bit picks stream or register for transmit signaling.
// - Source bit zero means stream, one means register.
module ecs_cas_core #(
	parameter int PERIOD_CYC = ecs_pkg::MF_PERIOD_CYC
) (
	input wire logic mclk, // 25 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic [11:0] reg_addr, // Register byte address
	input wire logic [15:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [15:0] reg_rdata, // Read data, cycle after strobe
	input wire ecs_pkg::ecs_ts16_in_type rx_ts16, // Received timeslot 16
	input wire logic tx_ts16_req, // Framer wants next timeslot 16
	output logic [7:0] tx_ts16_data, // Timeslot 16 byte, bit 1 in bit 7
	output logic [1:0] tx_ts16_insert, // Nibble insert, [1] upper
	input wire ecs_pkg::ecs_stream_in_type signaling_in_stream, // Input control stream
	input wire logic cst_out_req, // Output stream slot request
	input wire logic [4:0] cst_out_slot, // Requested backplane slot
	output logic [7:0] cst_out_data, // Output stream byte
	output logic cst_out_oe, // Output stream drive enable
	output logic control_stream_rate_sel, // High selects 8.192 Mbit/s
	output logic backplane_format_sel, // Backplane format select
	output logic multiframe_sync_loss, // Multiframe not aligned
	output logic receive_freeze_flag // Receive signaling frozen
);
	localparam int TW = $clog2(PERIOD_CYC);

	if (PERIOD_CYC < 2) begin : g_chk
		$error("PERIOD_CYC must be at least 2");
	end

	// Maps a backplane slot to a channel; zero for slots 0 and 16
	function automatic logic [4:0] slot_to_chan(input logic [4:0] s);
		if (s == 5'h00 || s == 5'h10) begin
			return 5'h00;
		end
		return (s > 5'h10) ? 5'(s - 5'h01) : s;
	endfunction

	// Decodes a per-channel page address into a valid channel or zero
	function automatic logic [4:0] page_chan(input logic [11:0] a, input logic [3:0] pg);
		if (a[11:8] != pg || a[7] || a[1:0] != 2'h0 || a[6:2] == 5'h00 ||
			a[6:2] > ecs_pkg::LAST_CHAN) begin
			return 5'h00;
		end
		return a[6:2];
	endfunction

	logic [15:0] global_stream_config, alarm_framing_control, interrupt_io_control;
	logic [15:0] datalink_signaling_control, signaling_interrupt_period;
	logic [15:0] signaling_control_data, hdlc_common_channel_control;
	logic [15:0] national_interrupt_mask;
	logic [15:0] next_global_stream_config, next_alarm_framing_control;
	logic [15:0] next_interrupt_io_control, next_datalink_signaling_control;
	logic [15:0] next_signaling_interrupt_period, next_signaling_control_data;
	logic [15:0] next_hdlc_common_channel_control, next_national_interrupt_mask;
	logic [3:0] tx_reg [0:31];
	logic [3:0] next_tx_reg [0:31];
	logic [1:0] ts_ctl [0:31];
	logic [1:0] next_ts_ctl [0:31];
	logic [3:0] tx_stream [0:31];
	logic [3:0] next_tx_stream [0:31];
	logic cas_active, ais_tx, sig_out_en, rx_out_sel, deb_en;

	// Control and per-channel transmit state written by software and by the input stream
	always_comb begin
		logic [4:0] c;
		c = 5'h00;
		next_global_stream_config = global_stream_config;
		next_alarm_framing_control = alarm_framing_control;
		next_interrupt_io_control = interrupt_io_control;
		next_datalink_signaling_control = datalink_signaling_control;
		next_signaling_interrupt_period = signaling_interrupt_period;
		next_signaling_control_data = signaling_control_data;
		next_hdlc_common_channel_control = hdlc_common_channel_control;
		next_national_interrupt_mask = national_interrupt_mask;
		next_tx_reg = tx_reg;
		next_ts_ctl = ts_ctl;
		next_tx_stream = tx_stream;
		if (reg_wr) begin
			case (reg_addr)
				ecs_pkg::ADDR_GLOBAL_STREAM_CONFIG: next_global_stream_config = reg_wdata;
				ecs_pkg::ADDR_ALARM_FRAMING_CONTROL: next_alarm_framing_control = reg_wdata;
				ecs_pkg::ADDR_INTERRUPT_IO_CONTROL: next_interrupt_io_control = reg_wdata;
				ecs_pkg::ADDR_DATALINK_SIGNALING_CONTROL: begin
					next_datalink_signaling_control = reg_wdata;
				end
				ecs_pkg::ADDR_SIGNALING_INTERRUPT_PERIOD: begin
					next_signaling_interrupt_period = reg_wdata;
				end
				ecs_pkg::ADDR_SIGNALING_CONTROL_DATA: next_signaling_control_data = reg_wdata;
				ecs_pkg::ADDR_HDLC_COMMON_CHANNEL_CONTROL: begin
					next_hdlc_common_channel_control = reg_wdata;
				end
				ecs_pkg::ADDR_NATIONAL_INTERRUPT_MASK: next_national_interrupt_mask = reg_wdata;
				default: begin
					c = page_chan(reg_addr, ecs_pkg::PAGE_TX_SIGNALING);
					if (c != 5'h00) begin
						next_tx_reg[c] = reg_wdata[3:0];
					end
					c = page_chan(reg_addr, ecs_pkg::PAGE_TIMESLOT_CONTROL);
					if (c != 5'h00) begin
						next_ts_ctl[c] = reg_wdata[1:0];
					end
				end
			endcase
		end
		// Stream nibble sits in the low bits of the slot byte, A in bit 3
		c = slot_to_chan(signaling_in_stream.slot);
		if (signaling_in_stream.valid && c != 5'h00) begin
			next_tx_stream[c] = signaling_in_stream.data[3:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			global_stream_config <= ecs_pkg::RST_REG;
			alarm_framing_control <= ecs_pkg::RST_REG;
			interrupt_io_control <= ecs_pkg::RST_REG;
			datalink_signaling_control <= ecs_pkg::RST_REG;
			signaling_interrupt_period <= ecs_pkg::RST_REG;
			signaling_control_data <= ecs_pkg::RST_REG;
			hdlc_common_channel_control <= ecs_pkg::RST_REG;
			national_interrupt_mask <= ecs_pkg::RST_REG;
			for (int i = 0; i < 32; i++) begin
				tx_reg[i] <= ecs_pkg::RST_NIBBLE;
				ts_ctl[i] <= 2'h0;
				tx_stream[i] <= ecs_pkg::RST_NIBBLE;
			end
		end else begin
			global_stream_config <= next_global_stream_config;
			alarm_framing_control <= next_alarm_framing_control;
			interrupt_io_control <= next_interrupt_io_control;
			datalink_signaling_control <= next_datalink_signaling_control;
			signaling_interrupt_period <= next_signaling_interrupt_period;
			signaling_control_data <= next_signaling_control_data;
			hdlc_common_channel_control <= next_hdlc_common_channel_control;
			national_interrupt_mask <= next_national_interrupt_mask;
			tx_reg <= next_tx_reg;
			ts_ctl <= next_ts_ctl;
			tx_stream <= next_tx_stream;
		end
	end

	// Mode decode; common-channel use in any form shuts signaling off
	assign cas_active = !alarm_framing_control[ecs_pkg::BIT_IMA_MODE] &&
		!datalink_signaling_control[ecs_pkg::BIT_COMMON_SIG_SEL] &&
		!datalink_signaling_control[ecs_pkg::BIT_RX_TRANSPARENT] &&
		(hdlc_common_channel_control[2:0] == 3'h0);
	assign ais_tx = alarm_framing_control[ecs_pkg::BIT_TS16_AIS];
	assign sig_out_en = interrupt_io_control[ecs_pkg::BIT_OUT_ENABLE];
	assign rx_out_sel = interrupt_io_control[ecs_pkg::BIT_RX_OUT_SEL];
	assign deb_en = signaling_control_data[ecs_pkg::BIT_DEBOUNCE_EN];
	assign control_stream_rate_sel = global_stream_config[ecs_pkg::BIT_RATE_SEL];
	assign backplane_format_sel = global_stream_config[ecs_pkg::BIT_FORMAT_SEL];

	// Receive alignment, debounce and receive signaling store
	ecs_pkg::ecs_align_state_type state, next_state;
	logic [3:0] rx_fcnt, next_rx_fcnt;
	logic [3:0] rx_sig [0:31];
	logic [3:0] next_rx_sig [0:31];
	logic [3:0] cand [0:31];
	logic [3:0] next_cand [0:31];
	logic [2:0] stable [0:31];
	logic [2:0] next_stable [0:31];
	logic any_change;

	always_comb begin
		logic [4:0] c;
		logic [3:0] n;
		logic accept;
		c = 5'h00;
		n = 4'h0;
		accept = 1'b0;
		next_state = state;
		next_rx_fcnt = rx_fcnt;
		next_rx_sig = rx_sig;
		next_cand = cand;
		next_stable = stable;
		any_change = 1'b0;
		if (rx_ts16.valid) begin
			case (state)
				ecs_pkg::ST_HUNT: begin
					if (rx_ts16.basic_sync && rx_ts16.data[7:4] == ecs_pkg::ALIGN_NIBBLE) begin
						next_state = ecs_pkg::ST_SYNC;
						next_rx_fcnt = 4'h1;
					end
				end
				ecs_pkg::ST_SYNC: begin
					next_rx_fcnt = 4'(rx_fcnt + 4'h1);
					if (!rx_ts16.basic_sync) begin
						next_state = ecs_pkg::ST_HUNT;
					end else if (rx_fcnt == 4'h0) begin
						if (rx_ts16.data[7:4] != ecs_pkg::ALIGN_NIBBLE) begin
							next_state = ecs_pkg::ST_HUNT;
						end
					end else if (cas_active) begin
						// Upper nibble is channel k, lower is channel k+15
						for (int h = 0; h < 2; h++) begin
							c = (h == 0) ? 5'(rx_fcnt) : 5'(rx_fcnt) + ecs_pkg::LOW_CHAN_OFS;
							n = (h == 0) ? rx_ts16.data[7:4] : rx_ts16.data[3:0];
							if (n == cand[c]) begin
								if (stable[c] != 3'h7) begin
									next_stable[c] = 3'(stable[c] + 3'h1);
								end
							end else begin
								next_cand[c] = n;
								next_stable[c] = 3'h0;
							end
							// Seventh matching multiframe in a row completes 14 msec
							accept = !deb_en || (n == cand[c] &&
								stable[c] >= 3'(ecs_pkg::DEBOUNCE_MF - 2));
							if (accept && n != rx_sig[c]) begin
								next_rx_sig[c] = n;
								if (!ts_ctl[c][ecs_pkg::BIT_CLEAR_CHANNEL]) begin
									any_change = 1'b1;
								end
							end
						end
					end
				end
				default: next_state = ecs_pkg::ST_HUNT;
			endcase
		end
	end

	// Out of alignment nothing above updates, so receive values hold
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= ecs_pkg::ST_HUNT;
			rx_fcnt <= 4'h0;
			for (int i = 0; i < 32; i++) begin
				rx_sig[i] <= ecs_pkg::RST_NIBBLE;
				cand[i] <= ecs_pkg::RST_NIBBLE;
				stable[i] <= 3'h0;
			end
		end else begin
			state <= next_state;
			rx_fcnt <= next_rx_fcnt;
			rx_sig <= next_rx_sig;
			cand <= next_cand;
			stable <= next_stable;
		end
	end

	assign multiframe_sync_loss = (state != ecs_pkg::ST_SYNC);
	assign receive_freeze_flag = multiframe_sync_loss;

	// Free-running period timer and change reporting
	logic [TW-1:0] tmr, next_tmr;
	logic [2:0] pcnt, next_pcnt;
	logic pend, next_pend, latch_st, next_latch_st, irq_st, next_irq_st;
	logic tick, period_end, int_set, rd_latch, rd_irq;
	logic [2:0] period_last;

	always_comb begin
		tick = (tmr == TW'(PERIOD_CYC - 1));
		case (signaling_interrupt_period[1:0])
			ecs_pkg::PERIOD_2MS: period_last = ecs_pkg::TICKS_2MS_LAST;
			ecs_pkg::PERIOD_8MS: period_last = ecs_pkg::TICKS_8MS_LAST;
			default: period_last = ecs_pkg::TICKS_16MS_LAST;
		endcase
		period_end = tick && (pcnt >= period_last);
		next_tmr = tick ? '0 : TW'(tmr + 1'b1);
		next_pcnt = period_end ? 3'h0 : (tick ? 3'(pcnt + 3'h1) : pcnt);
		rd_latch = reg_rd && reg_addr == ecs_pkg::ADDR_SIGNALING_LATCH_STATUS;
		rd_irq = reg_rd && reg_addr == ecs_pkg::ADDR_SIGNALING_INTERRUPT_STATUS;
		// One pending flag per period folds many changes into one event
		next_pend = any_change || (pend && !period_end);
		int_set = period_end && pend &&
			!national_interrupt_mask[ecs_pkg::BIT_CHANGE];
		// Set wins over a read-clear in the same cycle
		next_latch_st = any_change || (latch_st && !rd_latch);
		next_irq_st = int_set || (irq_st && !rd_irq);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tmr <= '0;
			pcnt <= 3'h0;
			pend <= 1'b0;
			latch_st <= 1'b0;
			irq_st <= 1'b0;
		end else begin
			tmr <= next_tmr;
			pcnt <= next_pcnt;
			pend <= next_pend;
			latch_st <= next_latch_st;
			irq_st <= next_irq_st;
		end
	end

	// Transmit timeslot 16 builder; its frame count ignores CRC-4 framing
	logic [3:0] tx_fcnt, next_tx_fcnt;
	logic [7:0] next_tx_ts16_data;
	logic [1:0] next_tx_ts16_insert;

	function automatic logic [3:0] tx_nibble(input logic [4:0] c);
		return ts_ctl[c][ecs_pkg::BIT_TX_SOURCE_SEL] ? tx_reg[c] : tx_stream[c];
	endfunction

	always_comb begin
		logic [4:0] lo;
		lo = 5'(tx_fcnt) + ecs_pkg::LOW_CHAN_OFS;
		next_tx_fcnt = tx_fcnt;
		next_tx_ts16_data = tx_ts16_data;
		next_tx_ts16_insert = tx_ts16_insert;
		if (tx_ts16_req) begin
			next_tx_fcnt = (tx_fcnt == ecs_pkg::LAST_FRAME) ? 4'h0 : 4'(tx_fcnt + 4'h1);
			if (tx_fcnt == 4'h0) begin
				// Alignment nibble, spare bits high, alarm bit from receive state
				next_tx_ts16_data = {ecs_pkg::ALIGN_NIBBLE, 1'b1, multiframe_sync_loss,
					2'b11};
				next_tx_ts16_insert = 2'b11;
			end else begin
				next_tx_ts16_data = {tx_nibble(5'(tx_fcnt)), tx_nibble(lo)};
				next_tx_ts16_insert = {!ts_ctl[5'(tx_fcnt)][ecs_pkg::BIT_CLEAR_CHANNEL],
					!ts_ctl[lo][ecs_pkg::BIT_CLEAR_CHANNEL]};
			end
			if (ais_tx || !cas_active) begin
				next_tx_ts16_insert = 2'b00;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_fcnt <= 4'h0;
			tx_ts16_data <= 8'hFF;
			tx_ts16_insert <= 2'b00;
		end else begin
			tx_fcnt <= next_tx_fcnt;
			tx_ts16_data <= next_tx_ts16_data;
			tx_ts16_insert <= next_tx_ts16_insert;
		end
	end

	// Output control stream and register read-back
	logic [7:0] next_cst_out_data;
	logic next_cst_out_oe;
	logic [15:0] next_reg_rdata;

	always_comb begin
		logic [4:0] c;
		c = slot_to_chan(cst_out_slot);
		next_cst_out_data = {ecs_pkg::UNUSED_NIBBLE_FILL, rx_sig[c]};
		next_cst_out_oe = cst_out_req && c != 5'h00 && sig_out_en && rx_out_sel;
		next_reg_rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				ecs_pkg::ADDR_GLOBAL_STREAM_CONFIG: next_reg_rdata = global_stream_config;
				ecs_pkg::ADDR_ALARM_FRAMING_CONTROL: next_reg_rdata = alarm_framing_control;
				ecs_pkg::ADDR_INTERRUPT_IO_CONTROL: next_reg_rdata = interrupt_io_control;
				ecs_pkg::ADDR_DATALINK_SIGNALING_CONTROL: begin
					next_reg_rdata = datalink_signaling_control;
				end
				ecs_pkg::ADDR_SIGNALING_INTERRUPT_PERIOD: begin
					next_reg_rdata = signaling_interrupt_period;
				end
				ecs_pkg::ADDR_SIGNALING_CONTROL_DATA: begin
					next_reg_rdata = signaling_control_data;
					next_reg_rdata[ecs_pkg::BIT_FREEZE_FLAG] = receive_freeze_flag;
				end
				ecs_pkg::ADDR_HDLC_COMMON_CHANNEL_CONTROL: begin
					next_reg_rdata = hdlc_common_channel_control;
				end
				ecs_pkg::ADDR_SYNC_REMOTE_STATUS: begin
					next_reg_rdata[ecs_pkg::BIT_SYNC_LOSS] = multiframe_sync_loss;
				end
				ecs_pkg::ADDR_SIGNALING_LATCH_STATUS: next_reg_rdata[ecs_pkg::BIT_CHANGE] = latch_st;
				ecs_pkg::ADDR_SIGNALING_INTERRUPT_STATUS: next_reg_rdata[ecs_pkg::BIT_CHANGE] = irq_st;
				ecs_pkg::ADDR_NATIONAL_INTERRUPT_MASK: next_reg_rdata = national_interrupt_mask;
				default: begin
					c = page_chan(reg_addr, ecs_pkg::PAGE_TX_SIGNALING);
					if (c != 5'h00) begin
						next_reg_rdata = {12'h000, tx_reg[c]};
					end
					c = page_chan(reg_addr, ecs_pkg::PAGE_RX_SIGNALING);
					if (c != 5'h00) begin
						next_reg_rdata = {12'h000, rx_sig[c]};
					end
					c = page_chan(reg_addr, ecs_pkg::PAGE_TIMESLOT_CONTROL);
					if (c != 5'h00) begin
						next_reg_rdata = {14'h0000, ts_ctl[c]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cst_out_data <= 8'hFF;
			cst_out_oe <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			cst_out_data <= next_cst_out_data;
			cst_out_oe <= next_cst_out_oe;
			reg_rdata <= next_reg_rdata;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_mf_frame_wrap: assert property (tx_ts16_req && tx_fcnt == 4'hF |=> tx_fcnt == 4'h0)
		else $error("transmit multiframe did not wrap after frame 15");
	a_align_pattern: assert property (tx_ts16_req && tx_fcnt == 4'h0 && cas_active && !ais_tx
		|=> tx_ts16_data[7:4] == 4'h0 && tx_ts16_insert == 2'b11)
		else $error("frame 0 lacks alignment nibble");
	a_spare_bits: assert property (tx_ts16_req && tx_fcnt == 4'h0
		|=> tx_ts16_data[3] && tx_ts16_data[1] && tx_ts16_data[0])
		else $error("spare bits not sent as one");
	a_alarm_bit: assert property (tx_ts16_req && tx_fcnt == 4'h0
		|=> tx_ts16_data[2] == $past(multiframe_sync_loss))
		else $error("remote multiframe alarm bit wrong");
	a_ais_blocks: assert property (tx_ts16_req && ais_tx |=> tx_ts16_insert == 2'b00)
		else $error("signaling inserted during timeslot 16 alarm");
	a_out_enable: assert property (cst_out_oe |-> $past(sig_out_en) && $past(rx_out_sel))
		else $error("output stream driven without both enables");
	a_rx_frozen: assert property (multiframe_sync_loss |-> !any_change ##1 receive_freeze_flag
		|| !multiframe_sync_loss)
		else $error("receive signaling changed while frozen");
	a_irq_paced: assert property (int_set |-> period_end ##1 !int_set)
		else $error("change interrupt outside period boundary");
	a_mask_blocks: assert property (national_interrupt_mask[0] |-> !int_set)
		else $error("masked change interrupt was set");
	a_latch_set: assert property (any_change |=> latch_st)
		else $error("change latch not set");
endmodule

// File: dv/ecs_line_model.sv
`timescale 1ns/1ps
// Far-end line: one timeslot-16 byte every fourth clock while running
module ecs_line_model (
	input wire logic mclk, // Clock
	input wire logic run, // Send frames
	input wire logic bad_align, // Spoil the frame 0 pattern
	input wire logic [3:0] sig_base, // Nibble for channels 1 to 15
	output ecs_pkg::ecs_ts16_in_type rx_ts16 // Line byte to the framer
);
	logic [1:0] ph;
	logic [3:0] fr;
	initial begin
		ph = 2'h0;
		fr = 4'h0;
		rx_ts16 = '0;
	end
	// Data toggles between frames so a stale byte never passes for a valid one
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		rx_ts16.valid <= run && ph == 2'h0;
		rx_ts16.basic_sync <= 1'b1;
		if (run && ph == 2'h0) begin
			fr <= fr + 4'h1;
			if (fr == 4'h0)
				rx_ts16.data <= {(bad_align ? 4'h8 : 4'h0), 4'hB};
			else
				rx_ts16.data <= {sig_base, ~sig_base};
		end else
			rx_ts16.data <= ~rx_ts16.data;
	end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic mclk, srst, reg_wr, reg_rd, tx_ts16_req, cst_out_req, run, bad_align;
	logic cst_out_oe, rate_sel, fmt_sel, sync_loss, freeze;
	logic [1:0] tx_ts16_insert;
	logic [3:0] sig_base;
	logic [4:0] cst_out_slot;
	logic [7:0] tx_ts16_data, cst_out_data;
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	ecs_pkg::ecs_ts16_in_type rx_ts16;
	ecs_pkg::ecs_stream_in_type sin;
	int err_total = 0;
	int n_compared = 0;
	int fcnt = 0;
	// Short period keeps the interrupt pacing quick
	ecs_cas_core #(.PERIOD_CYC(20)) ecs_cas_core_i (.mclk(mclk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_ts16(rx_ts16), .tx_ts16_req(tx_ts16_req),
		.tx_ts16_data(tx_ts16_data), .tx_ts16_insert(tx_ts16_insert),
		.signaling_in_stream(sin), .cst_out_req(cst_out_req), .cst_out_slot(cst_out_slot),
		.cst_out_data(cst_out_data), .cst_out_oe(cst_out_oe), .control_stream_rate_sel(rate_sel),
		.backplane_format_sel(fmt_sel), .multiframe_sync_loss(sync_loss),
		.receive_freeze_flag(freeze));
	ecs_line_model ecs_line_model_i (.mclk(mclk), .run(run), .bad_align(bad_align),
		.sig_base(sig_base), .rx_ts16(rx_ts16));
	task results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task ck(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bus tasks: strobes last one cycle, read data taken in the cycle after
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		// Mid-cycle sample, clear of the edge that zeroes the read data
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task rc(input logic [11:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		ck(d, e);
	endtask
	// Requests transmit bytes until frame k, then checks that one
	task tf(input int k, input logic [7:0] e, input logic [1:0] ei);
		int f;
		do begin
			f = fcnt;
			fcnt = (fcnt + 1) % 16;
			@(posedge mclk);
			tx_ts16_req <= 1'b1;
			@(posedge mclk);
			tx_ts16_req <= 1'b0;
			@(posedge mclk);
		end while (f != k);
		ck({6'h00, tx_ts16_insert, tx_ts16_data}, {6'h00, ei, e});
	endtask
	task co(input logic [4:0] s, input logic [7:0] e, input logic eo);
		@(posedge mclk);
		cst_out_req <= 1'b1;
		cst_out_slot <= s;
		@(posedge mclk);
		cst_out_req <= 1'b0;
		// The enable stands one cycle only, so look mid-cycle
		@(negedge mclk);
		ck({7'h00, cst_out_oe, cst_out_data}, {7'h00, eo, e});
	endtask
	task si(input logic [4:0] s, input logic [7:0] d);
		@(posedge mclk);
		sin <= '{1'b1, s, d};
		@(posedge mclk);
		sin.valid <= 1'b0;
	endtask
	// Bounded poll of the sync status; running out counts as a mismatch
	task wsync(input logic v);
		int i;
		logic [15:0] d;
		for (i = 0; i < 60; i++) begin
			rd(12'h040, d);
			if (d[0] === v)
				break;
		end
		ck({15'h0000, d[0]}, {15'h0000, v});
		if (i == 60)
			results();
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		{srst, reg_wr, reg_rd, tx_ts16_req, cst_out_req, run, bad_align} = 7'h40;
		{reg_addr, reg_wdata, cst_out_slot, sin} = '0;
		sig_base = 4'h5;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		rc(12'h040, 16'h0001);
		rc(12'h7FC, 16'h0000);
		tf(0, 8'h0F, 2'b11);
		wr(12'h900, 16'h0003);
		rc(12'h900, 16'h0003);
		ck({14'h0000, fmt_sel, rate_sel}, 16'h0003);
		$display("test reset done");
		wr(12'h00C, 16'h0000);
		wr(12'h018, 16'h0000);
		run <= 1'b1;
		wsync(1'b0);
		// Let a whole multiframe and its interrupt period go by first
		repeat (100) @(posedge mclk);
		rc(12'h504, 16'h0005);
		rc(12'h540, 16'h000A);
		rc(12'h098, 16'h0001);
		rc(12'h0D8, 16'h0001);
		$display("test receive done");
		wr(12'h404, 16'h0003);
		wr(12'h604, 16'h0002);
		wr(12'h640, 16'h0001);
		si(5'h01, 8'h07);
		si(5'h02, 8'h0C);
		tf(0, 8'h0B, 2'b11);
		tf(1, 8'h3F, 2'b10);
		tf(2, 8'hCF, 2'b11);
		wr(12'h000, 16'h0001);
		tf(0, 8'h0B, 2'b00);
		wr(12'h000, 16'h0002);
		tf(0, 8'h0B, 2'b00);
		wr(12'h000, 16'h0000);
		$display("test transmit done");
		co(5'h01, 8'hF5, 1'b0);
		wr(12'h008, 16'h0003);
		co(5'h01, 8'hF5, 1'b1);
		co(5'h11, 8'hFA, 1'b1);
		wr(12'h008, 16'h0001);
		co(5'h01, 8'hF5, 1'b0);
		$display("test output stream done");
		wr(12'h118, 16'h0001);
		bad_align <= 1'b1;
		wsync(1'b1);
		ck({14'h0000, freeze, sync_loss}, 16'h0003);
		sig_base <= 4'h9;
		repeat (140) @(posedge mclk);
		rc(12'h504, 16'h0005);
		rc(12'h014, 16'h0002);
		bad_align <= 1'b0;
		wsync(1'b0);
		ck({14'h0000, freeze, sync_loss}, 16'h0000);
		repeat (100) @(posedge mclk);
		rc(12'h504, 16'h0009);
		rc(12'h0D8, 16'h0000);
		rc(12'h098, 16'h0001);
		$display("test freeze done");
		wr(12'h014, 16'h0001);
		sig_base <= 4'h3;
		// Three multiframes is well short of the seven that debounce wants
		repeat (192) @(posedge mclk);
		rc(12'h504, 16'h0009);
		repeat (384) @(posedge mclk);
		rc(12'h504, 16'h0003);
		$display("test debounce done");
		results();
	end
endmodule
